// ### hw/hbp_host_port.sv
// Host bus port of a serial bus link controller: pins to core strobes.
// Assumes the core register file and FIFOs answer on the same clock.
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port
    import hbp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_access_sel_n,
    input wire logic i_write_sel_n,
    input wire logic [0:hbp_pkg::HBP_ADDR_W-1] i_host_word_select,
    input wire logic [0:hbp_pkg::HBP_DATA_W-1] i_host_data,
    output logic [0:hbp_pkg::HBP_DATA_W-1] o_host_data,
    output logic o_host_data_oe,
    output logic o_access_done_n,
    output logic o_int_n,
    output logic o_core_rd,
    output logic o_core_wr,
    output logic [hbp_pkg::HBP_IDX_W-1:0] o_core_index,
    output logic [0:hbp_pkg::HBP_DATA_W-1] o_core_wdata,
    input wire logic [0:hbp_pkg::HBP_DATA_W-1] i_core_rdata,
    input wire logic i_core_done,
    input wire logic i_core_irq
);
    import hbp_pkg::*;

    // All state of the port in one record
    typedef struct packed {
        logic cs_m; // Select, first sync stage
        logic cs_s; // Select, second sync stage
        logic wr_m; // Write select, first stage
        logic wr_s; // Write select, second stage
        logic [0:HBP_ADDR_W-1] adr_m; // Address, first stage
        logic [0:HBP_ADDR_W-1] adr_s; // Address, second stage
        logic [0:HBP_DATA_W-1] dat_m; // Data in, first stage
        logic [0:HBP_DATA_W-1] dat_s; // Data in, second stage
        hbp_state_t state; // Access sequence
        logic is_read; // Current access is a read
        logic rd; // Core read strobe
        logic wr; // Core write strobe
        logic [HBP_IDX_W-1:0] idx; // Quadlet index to core
        logic [0:HBP_DATA_W-1] wdata; // Write data to core
        logic [0:HBP_DATA_W-1] rdata; // Read data to pins
        logic oe; // Data bus drive enable
        logic ack_n; // Access acknowledge
        logic int_n; // Interrupt pin
    } hbp_regs_t;

    hbp_regs_t st_reg;
    hbp_regs_t st_next;

    // Next-state logic for the whole port
    always_comb begin
        st_next = st_reg;
        // Pins come from the host side, so two flops before any use
        st_next.cs_m = i_access_sel_n;
        st_next.cs_s = st_reg.cs_m;
        st_next.wr_m = i_write_sel_n;
        st_next.wr_s = st_reg.wr_m;
        st_next.adr_m = i_host_word_select;
        st_next.adr_s = st_reg.adr_m;
        st_next.dat_m = i_host_data;
        st_next.dat_s = st_reg.dat_m;
        // Strobes last one cycle only
        st_next.rd = HBP_LOW;
        st_next.wr = HBP_LOW;
        // Core interrupt level drives the active-low pin
        st_next.int_n = ~i_core_irq;
        case (st_reg.state)
            HBP_IDLE: begin
                st_next.ack_n = HBP_HIGH;
                st_next.oe = HBP_LOW;
                // Select low opens an access
                if (!st_reg.cs_s) begin
                    // Bit 0 is the MSB; lines 6 and 7 are ignored
                    st_next.idx = st_reg.adr_s[0:HBP_IDX_W-1];
                    st_next.wdata = st_reg.dat_s;
                    st_next.is_read = st_reg.wr_s;
                    st_next.rd = st_reg.wr_s;
                    st_next.wr = ~st_reg.wr_s;
                    st_next.state = HBP_WAIT;
                end
            end
            HBP_WAIT: begin
                // Hold off acknowledge until the core has finished
                if (i_core_done) begin
                    st_next.ack_n = HBP_LOW;
                    st_next.rdata = i_core_rdata;
                    st_next.oe = st_reg.is_read;
                    st_next.state = HBP_ACK;
                end
            end
            HBP_ACK: begin
                // Keep data and acknowledge until the host lets go
                if (st_reg.cs_s) begin
                    st_next.ack_n = HBP_HIGH;
                    st_next.oe = HBP_LOW;
                    st_next.state = HBP_IDLE;
                end
            end
            default: begin
                // Recover from an illegal code into a quiet idle
                st_next.ack_n = HBP_HIGH;
                st_next.oe = HBP_LOW;
                st_next.state = HBP_IDLE;
            end
        endcase
    end

    // State register; all of it runs on the host bus clock
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_reg.cs_m <= HBP_HIGH;
            st_reg.cs_s <= HBP_HIGH;
            st_reg.wr_m <= HBP_HIGH;
            st_reg.wr_s <= HBP_HIGH;
            st_reg.adr_m <= '0;
            st_reg.adr_s <= '0;
            st_reg.dat_m <= HBP_DATA_RST;
            st_reg.dat_s <= HBP_DATA_RST;
            st_reg.state <= HBP_IDLE;
            st_reg.is_read <= HBP_LOW;
            st_reg.rd <= HBP_LOW;
            st_reg.wr <= HBP_LOW;
            st_reg.idx <= HBP_IDX_RST;
            st_reg.wdata <= HBP_DATA_RST;
            st_reg.rdata <= HBP_DATA_RST;
            st_reg.oe <= HBP_LOW;
            st_reg.ack_n <= HBP_HIGH;
            st_reg.int_n <= HBP_HIGH;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from flops
    assign o_host_data = st_reg.rdata;
    assign o_host_data_oe = st_reg.oe;
    assign o_access_done_n = st_reg.ack_n;
    assign o_int_n = st_reg.int_n;
    assign o_core_rd = st_reg.rd;
    assign o_core_wr = st_reg.wr;
    assign o_core_index = st_reg.idx;
    assign o_core_wdata = st_reg.wdata;

    // Acknowledge stays high outside an access
    a_ack_idle_high: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (st_reg.state == HBP_IDLE) |-> o_access_done_n)
        else $error("acknowledge low while idle");

    // Released select brings acknowledge back high next cycle
    a_ack_release: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (!o_access_done_n && st_reg.cs_s) |=> o_access_done_n)
        else $error("acknowledge not released after select");

    // Read strobe only from select low with write select high
    a_read_cause: assert property (
        @(posedge i_clock) disable iff (i_rst)
        o_core_rd |-> $past(!st_reg.cs_s && st_reg.wr_s))
        else $error("read strobe without read request");

    // Write strobe only from select low with write select low
    a_write_cause: assert property (
        @(posedge i_clock) disable iff (i_rst)
        o_core_wr |-> $past(!st_reg.cs_s && !st_reg.wr_s))
        else $error("write strobe without write request");

    // Each strobe lasts one cycle, never back to back
    a_strobe_single: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (o_core_rd || o_core_wr) |=> !(o_core_rd || o_core_wr))
        else $error("strobe longer than one cycle");

    // Core completion yields acknowledge on the next edge
    a_ack_on_done: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (st_reg.state == HBP_WAIT && i_core_done) |=> !o_access_done_n)
        else $error("acknowledge missing after core done");

    // Data bus driven only during an acknowledged read
    a_drive_read: assert property (
        @(posedge i_clock) disable iff (i_rst)
        o_host_data_oe |-> (!o_access_done_n && st_reg.is_read))
        else $error("data bus driven outside read acknowledge");

    // Released select frees the data bus on the next edge
    a_oe_release: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (o_host_data_oe && st_reg.cs_s) |=> !o_host_data_oe)
        else $error("data bus still driven after select release");

    // Acknowledge only falls out of the wait state
    a_ack_from_wait: assert property (
        @(posedge i_clock) disable iff (i_rst)
        $fell(o_access_done_n) |-> $past(st_reg.state == HBP_WAIT))
        else $error("acknowledge fell outside wait state");

    // Interrupt pin follows the core request one cycle later
    a_int_follow: assert property (
        @(posedge i_clock) disable iff (i_rst)
        i_core_irq |=> !o_int_n)
        else $error("interrupt pin not asserted");

    // Interrupt pin returns high once the core request is gone
    a_int_release: assert property (
        @(posedge i_clock) disable iff (i_rst)
        !i_core_irq |=> o_int_n)
        else $error("interrupt pin stuck low");

    // Index comes from the six most significant address bits
    a_index_msb: assert property (
        @(posedge i_clock) disable iff (i_rst)
        (o_core_rd || o_core_wr) |->
            o_core_index == $past(st_reg.adr_s[0:HBP_IDX_W-1]))
        else $error("index not from address bits 0 to 5");
endmodule
`default_nettype wire

// ### hw/hbp_pkg.sv
// Package for the serial bus link host port.
// Assumes one host bus clock domain and big-endian pin numbering.
package hbp_pkg;
    // Host data bus width, bit 0 is the most significant bit
    localparam int HBP_DATA_W = 32;
    // Host word select width, bit 0 is the most significant bit
    localparam int HBP_ADDR_W = 8;
    // Quadlet index width: word select bits 0 to 5
    localparam int HBP_IDX_W = 6;
    // Reset values
    localparam logic [HBP_DATA_W-1:0] HBP_DATA_RST = 32'h0000_0000;
    localparam logic [HBP_IDX_W-1:0] HBP_IDX_RST = 6'h00;
    localparam logic HBP_HIGH = 1'b1;
    localparam logic HBP_LOW = 1'b0;

    // Host port sequence states, one-hot
    typedef enum logic [2:0] {
        HBP_IDLE = 3'b001,
        HBP_WAIT = 3'b010,
        HBP_ACK = 3'b100
    } hbp_state_t;
endpackage

// ### sim/hbp_core_model.sv
// Core register file model behind the host port.
// Assumes strobes last one cycle and one access is outstanding.
`timescale 1ns/1ps
`default_nettype none
module hbp_core_model (
    input wire logic i_clock,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [5:0] i_index,
    input wire logic [0:31] i_wdata,
    input wire logic [3:0] i_delay,
    output logic [0:31] o_rdata,
    output logic o_done
);
    logic [0:31] mem [64]; // Quadlet store, one word per index
    logic [3:0] cnt; // Cycles left before done
    logic pend = 1'b0; // Slow answer outstanding
    // Done in strobe cycle when fast, later when slow
    assign o_done = ((i_rd | i_wr) && i_delay == 4'h0) ||
        (pend && cnt == 4'h0);
    // Read data is garbage unless done, so stale values never pass
    assign o_rdata = o_done ? mem[i_index] : ~mem[i_index];
    // Store writes and count the slow answer down
    always @(posedge i_clock) begin
        if (i_wr) mem[i_index] <= i_wdata;
        if ((i_rd | i_wr) && i_delay != 4'h0) begin
            pend <= 1'b1;
            cnt <= i_delay - 4'h1;
        end else if (pend && cnt == 4'h0) pend <= 1'b0;
        else if (pend) cnt <= cnt - 4'h1;
    end
endmodule
`default_nettype wire

// ### sim/hbp_host_port_tb.sv
// Self-checking bench for the host port, acting as host processor.
// Assumes the core model answers strobes with a settable delay.
`timescale 1ns/1ps
`default_nettype none
module hbp_host_port_tb;
    import hbp_pkg::*;
    logic i_clock = 1'b0, i_rst = 1'b1, sel_n = 1'b1, wr_n = 1'b1, irq = 1'b0;
    logic [0:7] addr = 8'h00;
    logic [0:31] hdata = 32'h0000_0000, rdata, cdata, wdat;
    logic [5:0] idx, last_idx = 6'h00;
    logic oe, ack_n, int_n, rd, wr, done;
    logic [3:0] delay = 4'h0; // Core answer delay
    int bad_count = 0, checked = 0;
    always #4 i_clock = ~i_clock;
    hbp_host_port i_hbp_host_port (.i_clock(i_clock), .i_rst(i_rst),
        .i_access_sel_n(sel_n), .i_write_sel_n(wr_n),
        .i_host_word_select(addr), .i_host_data(hdata), .o_host_data(rdata),
        .o_host_data_oe(oe), .o_access_done_n(ack_n), .o_int_n(int_n),
        .o_core_rd(rd), .o_core_wr(wr), .o_core_index(idx),
        .o_core_wdata(wdat), .i_core_rdata(cdata), .i_core_done(done),
        .i_core_irq(irq));
    hbp_core_model i_hbp_core_model (.i_clock(i_clock), .i_rd(rd),
        .i_wr(wr), .i_index(idx), .i_wdata(wdat), .i_delay(delay),
        .o_rdata(cdata), .o_done(done));
    // Remember the index of the latest core strobe
    always @(posedge i_clock) if (rd | wr) last_idx <= idx;
    task automatic check(input string nm, input logic [31:0] s, e);
        checked++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One host access; sample after edge updates have landed
    task automatic access(input logic w, input logic [0:7] a,
        input logic [0:31] d, output logic [0:31] q, output logic qoe);
        int n;
        n = 0;
        @(posedge i_clock);
        sel_n <= 1'b0;
        wr_n <= ~w;
        addr <= a;
        hdata <= d;
        do begin
            @(posedge i_clock);
            #1 n++;
        end while (ack_n !== 1'b0 && n < 30);
        // Two sync edges, a strobe edge, the core delay, one more edge
        check("ack_latency", 32'(n), 32'(delay) + 32'h4);
        q = rdata;
        qoe = oe;
        @(posedge i_clock);
        sel_n <= 1'b1;
        hdata <= ~d; // Released bus shows no stale value
        n = 0;
        do begin
            @(posedge i_clock);
            #1 n++;
        end while (ack_n !== 1'b1 && n < 30);
        check("ack_idle", {31'h0, ack_n}, 32'h1);
        check("ack_release", 32'(n), 32'h3);
    endtask
    // Write then read back one quadlet at the given word select
    task automatic t_wr_rd(input logic [0:7] a, input logic [0:31] d);
        logic [0:31] q;
        logic qoe;
        access(1'b1, a, d, q, qoe);
        check("wr_oe", {31'h0, qoe}, 32'h0);
        check("wr_index", {26'h0, last_idx}, {26'h0, a[0:5]});
        access(1'b0, a, 32'h0, q, qoe);
        check("rd_oe", {31'h0, qoe}, 32'h1);
        check("rd_data", q, d);
    endtask
    // Interrupt pin follows the core level exactly one edge later
    task automatic t_irq();
        @(posedge i_clock);
        irq <= 1'b1;
        #1 check("int_hold", {31'h0, int_n}, 32'h1);
        @(posedge i_clock);
        #1 check("int_set", {31'h0, int_n}, 32'h0);
        @(posedge i_clock);
        irq <= 1'b0;
        #1 check("int_stay", {31'h0, int_n}, 32'h0);
        @(posedge i_clock);
        #1 check("int_clr", {31'h0, int_n}, 32'h1);
    endtask
    task automatic complete_run();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Watchdog far beyond the expected run length
    initial begin
        #40000;
        bad_count++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge i_clock);
        i_rst <= 1'b0;
        #1 check("rst_ack", {31'h0, ack_n}, 32'h1);
        check("rst_oe", {31'h0, oe}, 32'h0);
        t_wr_rd(8'hFC, 32'hA5C3_0F01);
        t_wr_rd(8'h80, 32'h8000_0001);
        t_wr_rd(8'h04, 32'h0123_4567);
        delay <= 4'h6; // Slow core stretches the acknowledge
        t_wr_rd(8'hFC, 32'h5A3C_F0FE);
        delay <= 4'h0;
        t_irq();
        complete_run();
    end
endmodule
`default_nettype wire
